/* design/sram_host_map.svh */
// Timing and pin-level constants for the static memory host controller
`ifndef SRAM_HOST_MAP_SVH
`define SRAM_HOST_MAP_SVH

`define CLK_PERIOD_NS     100
`define ADDR_BITS         13
`define DATA_BITS         8
`define SYNC_STAGES       2
`define T_ACCESS_NS       100
`define T_WRITE_NS        60
`define T_RECOVER_NS      100
`define ACCESS_CYC        ((`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_CYC         ((`T_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVER_CYC       ((`T_RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RD_WAIT_CYC       (`ACCESS_CYC + 1 + `SYNC_STAGES)
`define CNT_BITS          4
`define CNT_ZERO          4'h0
`define CNT_ONE           4'h1
`define CS_LOW_IDLE       1'b1
`define CS_HIGH_IDLE      1'b0
`define STROBE_IDLE       1'b1

`endif

/* design/sram_host_pkg.sv */
// Types shared by the static memory host controller
package sram_host_pkg;
    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_RD_WAIT  = 3'b001,
        ST_WR_SETUP = 3'b010,
        ST_WR_PULSE = 3'b011,
        ST_WR_HOLD  = 3'b100,
        ST_TURN     = 3'b101,
        ST_RETAIN   = 3'b110,
        ST_RECOVER  = 3'b111
    } host_state_e;
endpackage

/* design/pin_sync.sv */
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_r;

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            stage1_r <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1_r <= async_in;
            sync_out <= stage1_r;
        end
    end
endmodule

/* design/sram_host_ctrl.sv */
// Host controller driving an asynchronous 8k x 8 static memory
`timescale 1ns/1ps
`include "sram_host_map.svh"

// Functional notes
// - Output gate does not affect writes; host keeps it high then.
// - Write window is the overlap of all three; data stable at its end.
// - Host never drives data pins while memory is in read output mode.
// - Host deselects the memory before low-supply retention begins.
module sram_host_ctrl #(
    parameter int ADDR_W = `ADDR_BITS,
    parameter int DATA_W = `DATA_BITS
) (
    input  wire logic              core_clk,
    input  wire logic              rstn,
    input  wire logic              req_valid,
    input  wire logic              req_write,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    output logic                   req_ready,
    output logic                   rsp_valid,
    output logic      [DATA_W-1:0] rsp_rdata,
    input  wire logic              retention_req,
    output logic                   retention_ack,
    output logic      [ADDR_W-1:0] word_addr,
    output logic                   chip_select_active_low,
    output logic                   chip_select_active_high,
    output logic                   write_strobe_n,
    output logic                   output_gate_n,
    input  wire logic [DATA_W-1:0] data_pins_i,
    output logic      [DATA_W-1:0] data_pins_o,
    output logic                   data_pins_oe
);
    import sram_host_pkg::*;

    localparam logic [`CNT_BITS-1:0] RD_WAIT_LAST = `CNT_BITS'(`RD_WAIT_CYC - 1);
    localparam logic [`CNT_BITS-1:0] WRITE_LAST   = `CNT_BITS'(`WRITE_CYC - 1);
    localparam logic [`CNT_BITS-1:0] RECOVER_LAST = `CNT_BITS'(`RECOVER_CYC - 1);
    localparam int WRITE_LEN = `WRITE_CYC;
    localparam int READ_LAT  = `RD_WAIT_CYC + 1;

    host_state_e          state_r;
    logic [`CNT_BITS-1:0] cnt_r;
    logic [DATA_W-1:0]    data_sync;
    logic                 go_rd;
    logic                 go_wr;
    logic                 cnt_done;

    pin_sync #(
        .WIDTH (DATA_W)
    ) u_data_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .async_in (data_pins_i),
        .sync_out (data_sync)
    );

    // Retention request takes priority over new accesses
    // Held low in reset so a request offered then is not lost
    assign req_ready     = (state_r == ST_IDLE) && !retention_req && rstn;
    assign go_rd         = req_ready && req_valid && !req_write;
    assign go_wr         = req_ready && req_valid && req_write;
    assign cnt_done      = (cnt_r == `CNT_ZERO);
    assign retention_ack = (state_r == ST_RETAIN);

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            state_r <= ST_IDLE;
            cnt_r   <= `CNT_ZERO;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (retention_req)
                        state_r <= ST_RETAIN;
                    else if (go_rd)
                    begin
                        state_r <= ST_RD_WAIT;
                        cnt_r   <= RD_WAIT_LAST;
                    end
                    else if (go_wr)
                        state_r <= ST_WR_SETUP;
                end
                ST_RD_WAIT:
                begin
                    if (cnt_done)
                        state_r <= ST_TURN;
                    else
                        cnt_r <= cnt_r - `CNT_ONE;
                end
                ST_WR_SETUP:
                begin
                    state_r <= ST_WR_PULSE;
                    cnt_r   <= WRITE_LAST;
                end
                ST_WR_PULSE:
                begin
                    if (cnt_done)
                        state_r <= ST_WR_HOLD;
                    else
                        cnt_r <= cnt_r - `CNT_ONE;
                end
                ST_WR_HOLD:
                    state_r <= ST_IDLE;
                ST_TURN:
                    state_r <= ST_IDLE;
                ST_RETAIN:
                begin
                    if (!retention_req)
                    begin
                        state_r <= ST_RECOVER;
                        cnt_r   <= RECOVER_LAST;
                    end
                end
                ST_RECOVER:
                begin
                    if (cnt_done)
                        state_r <= ST_IDLE;
                    else
                        cnt_r <= cnt_r - `CNT_ONE;
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // Pin drive; every strobe comes from a flop so no glitches reach the memory
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            word_addr               <= '0;
            chip_select_active_low  <= `CS_LOW_IDLE;
            chip_select_active_high <= `CS_HIGH_IDLE;
            write_strobe_n          <= `STROBE_IDLE;
            output_gate_n           <= `STROBE_IDLE;
            data_pins_o             <= '0;
            data_pins_oe            <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (go_rd)
                    begin
                        word_addr               <= req_addr;
                        chip_select_active_low  <= ~`CS_LOW_IDLE;
                        chip_select_active_high <= ~`CS_HIGH_IDLE;
                        output_gate_n           <= ~`STROBE_IDLE;
                    end
                    else if (go_wr)
                    begin
                        // Gate stays high so the memory never drives against us
                        word_addr               <= req_addr;
                        chip_select_active_low  <= ~`CS_LOW_IDLE;
                        chip_select_active_high <= ~`CS_HIGH_IDLE;
                        data_pins_o             <= req_wdata;
                        data_pins_oe            <= 1'b1;
                    end
                end
                ST_WR_SETUP:
                    write_strobe_n <= ~`STROBE_IDLE;
                ST_WR_PULSE:
                begin
                    if (cnt_done)
                        write_strobe_n <= `STROBE_IDLE;
                end
                ST_WR_HOLD:
                begin
                    // Data and select held one cycle past the strobe edge
                    chip_select_active_low  <= `CS_LOW_IDLE;
                    chip_select_active_high <= `CS_HIGH_IDLE;
                    data_pins_oe            <= 1'b0;
                end
                ST_RD_WAIT:
                begin
                    if (cnt_done)
                    begin
                        chip_select_active_low  <= `CS_LOW_IDLE;
                        chip_select_active_high <= `CS_HIGH_IDLE;
                        output_gate_n           <= `STROBE_IDLE;
                    end
                end
                default:
                begin
                    chip_select_active_low  <= `CS_LOW_IDLE;
                    chip_select_active_high <= `CS_HIGH_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end
        else
        begin
            rsp_valid <= (state_r == ST_RD_WAIT) && cnt_done;
            if ((state_r == ST_RD_WAIT) && cnt_done)
                rsp_rdata <= data_sync;
        end
    end

    property p_no_contention;
        @(posedge core_clk) disable iff (!rstn)
        !(data_pins_oe && !output_gate_n);
    endproperty
    a_no_contention: assert property (p_no_contention)
        else $error("host drives data while memory output gate is low");

    property p_turnaround;
        @(posedge core_clk) disable iff (!rstn)
        $rose(output_gate_n) |=> !data_pins_oe;
    endproperty
    a_turnaround: assert property (p_turnaround)
        else $error("host drove data right after read output ended");

    property p_gate_high_in_write;
        @(posedge core_clk) disable iff (!rstn)
        !write_strobe_n |-> output_gate_n;
    endproperty
    a_gate_high_in_write: assert property (p_gate_high_in_write)
        else $error("output gate low during write strobe");

    property p_window_driven;
        @(posedge core_clk) disable iff (!rstn)
        !write_strobe_n |-> data_pins_oe && !chip_select_active_low
            && chip_select_active_high;
    endproperty
    a_window_driven: assert property (p_window_driven)
        else $error("write strobe low without select or data drive");

    property p_data_hold;
        @(posedge core_clk) disable iff (!rstn)
        $rose(write_strobe_n) |-> data_pins_oe && $stable(data_pins_o)
            && !chip_select_active_low;
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("write data or select not held at end of write window");

    property p_strobe_width;
        @(posedge core_clk) disable iff (!rstn)
        $fell(write_strobe_n) |-> ##WRITE_LEN $rose(write_strobe_n);
    endproperty
    a_strobe_width: assert property (p_strobe_width)
        else $error("write strobe width wrong");

    property p_retention_deselect;
        @(posedge core_clk) disable iff (!rstn)
        retention_ack |-> chip_select_active_low && !chip_select_active_high
            && write_strobe_n && !data_pins_oe;
    endproperty
    a_retention_deselect: assert property (p_retention_deselect)
        else $error("memory selected during retention");

    property p_read_latency;
        @(posedge core_clk) disable iff (!rstn)
        go_rd |-> ##READ_LAT (rsp_valid && output_gate_n);
    endproperty
    a_read_latency: assert property (p_read_latency)
        else $error("read response not at expected cycle");

    property p_rsp_pulse;
        @(posedge core_clk) disable iff (!rstn)
        rsp_valid |=> !rsp_valid;
    endproperty
    a_rsp_pulse: assert property (p_rsp_pulse)
        else $error("read response longer than one cycle");
endmodule

/* verif/sram_device_model.sv */
// Behavioural model of the 8k x 8 asynchronous static memory
`timescale 1ns/1ps
`include "sram_host_map.svh"
module sram_device_model (
    input  wire logic [`ADDR_BITS-1:0] word_addr,
    input  wire logic                  chip_select_active_low,
    input  wire logic                  chip_select_active_high,
    input  wire logic                  write_strobe_n,
    input  wire logic                  output_gate_n,
    input  wire logic [`DATA_BITS-1:0] host_d,
    input  wire logic                  host_oe,
    output logic      [`DATA_BITS-1:0] data_pins,
    output logic                       clash
);
    // Left unwritten, so unwritten bytes read as unknown
    logic [`DATA_BITS-1:0] mem [0:8191];
    logic [`DATA_BITS-1:0] last_q;
    wire  [`DATA_BITS-1:0] dev_q;
    logic                  sel;
    logic                  dev_oe;
    logic                  wr_win;

    assign sel    = !chip_select_active_low && chip_select_active_high;
    assign dev_oe = sel && write_strobe_n && !output_gate_n;
    assign wr_win = sel && !write_strobe_n;
    // Old byte held briefly after an address change
    assign #10 dev_q = mem[word_addr];
    // Undriven bus shows the inverse of its last level
    assign data_pins = host_oe ? host_d : (dev_oe ? dev_q : ~last_q);

    initial
    begin
        last_q = 8'h00;
        clash  = 1'b0;
    end

    always @(host_oe, dev_oe, host_d, dev_q)
    begin
        if (host_oe)
            last_q = host_d;
        else if (dev_oe)
            last_q = dev_q;
        if (host_oe && dev_oe)
            clash = 1'b1;
    end

    always @(wr_win, word_addr, data_pins)
    begin
        if (wr_win)
            mem[word_addr] = data_pins;
    end
endmodule

/* verif/async_sram_8k_by_8_tb.sv */
// Self-checking testbench for the static memory host controller
`timescale 1ns/1ps
`include "sram_host_map.svh"
module async_sram_8k_by_8_tb;
    typedef struct {
        logic                  wr;
        logic [`ADDR_BITS-1:0] a;
        logic [`DATA_BITS-1:0] d;
    } row_s;
    logic                  core_clk, rstn, req_valid, req_write, req_ready;
    logic                  rsp_valid, retention_req, retention_ack, cs_lo, cs_hi;
    logic                  write_strobe_n, output_gate_n, data_pins_oe, clash;
    logic [`ADDR_BITS-1:0] req_addr, word_addr;
    logic [`DATA_BITS-1:0] req_wdata, rsp_rdata, data_pins_o, pins;
    int                    n_fail, total_checks;
    time                   t_take, t_rel;
    row_s                  rows [8];

    sram_host_ctrl i_dut (.core_clk(core_clk), .rstn(rstn), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .retention_req(retention_req), .retention_ack(retention_ack),
        .word_addr(word_addr), .chip_select_active_low(cs_lo),
        .chip_select_active_high(cs_hi), .write_strobe_n(write_strobe_n),
        .output_gate_n(output_gate_n), .data_pins_i(pins),
        .data_pins_o(data_pins_o), .data_pins_oe(data_pins_oe));

    sram_device_model i_mem (.word_addr(word_addr), .chip_select_active_low(cs_lo),
        .chip_select_active_high(cs_hi), .write_strobe_n(write_strobe_n),
        .output_gate_n(output_gate_n), .host_d(data_pins_o), .host_oe(data_pins_oe),
        .data_pins(pins), .clash(clash));

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1)
        begin
            n_fail++;
            $display("Error at %0t ns: %s", $time, msg);
        end
    endtask

    task chk_idle(input string msg);
        chk(cs_lo === 1'b1 && cs_hi === 1'b0 && write_strobe_n === 1'b1
            && output_gate_n === 1'b1 && data_pins_oe === 1'b0, msg);
    endtask

    task stop_test;
        $display("Checks %0d, failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task do_req(input logic wr, input logic [12:0] a, input logic [7:0] d);
        int i;
        int rsp_at;
        int rdy_at;
        rsp_at = 0;
        rdy_at = 0;
        i = 0;
        @(posedge core_clk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr  <= a;
        req_wdata <= d;
        do
        begin
            @(posedge core_clk);
            i++;
        end
        while (req_ready !== 1'b1 && i < 40);
        t_take = $time;
        chk(i < 40, "request not taken");
        req_valid <= 1'b0;
        for (i = 1; i <= 10 && rdy_at == 0; i++)
        begin
            @(posedge core_clk);
            #1;
            if (write_strobe_n === 1'b0)
                chk(data_pins_oe === 1'b1 && data_pins_o === d, "write data");
            if (rsp_valid === 1'b1)
            begin
                rsp_at = i;
                chk(rsp_rdata === d, "read data");
            end
            if (req_ready === 1'b1)
                rdy_at = i;
        end
        // Counted in edges after the taking edge, seen just after each edge
        chk(rsp_at == (wr ? 0 : `RD_WAIT_CYC), "answer timing");
        chk(rdy_at == (wr ? `WRITE_CYC + 2 : `RD_WAIT_CYC + 1), "ready timing");
    endtask

    initial
    begin
        #(100 * 3000);
        n_fail++;
        $display("Error at %0t ns: watchdog expired", $time);
        stop_test;
    end

    initial
    begin
        rstn = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 13'h0000;
        req_wdata = 8'h00;
        retention_req = 1'b0;
        rows = '{'{1'b1, 13'h0000, 8'ha5}, '{1'b1, 13'h1fff, 8'h5a},
                 '{1'b1, 13'h0aaa, 8'h3c}, '{1'b0, 13'h0000, 8'ha5},
                 '{1'b0, 13'h1fff, 8'h5a}, '{1'b1, 13'h0000, 8'h0f},
                 '{1'b0, 13'h0000, 8'h0f}, '{1'b0, 13'h0aaa, 8'h3c}};
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        #1;
        chk_idle("pins not idle after reset");
        foreach (rows[k])
            do_req(rows[k].wr, rows[k].a, rows[k].d);
        $display("Table test done");
        @(posedge core_clk);
        retention_req <= 1'b1;
        for (int i = 0; i < 4 && retention_ack !== 1'b1; i++)
        begin
            @(posedge core_clk);
            #1;
        end
        chk(retention_ack === 1'b1, "no retention ack");
        fork
            begin
                repeat (6)
                begin
                    @(posedge core_clk);
                    #1;
                    chk_idle("selected in retention");
                    chk(req_ready === 1'b0, "ready in retention");
                end
                @(posedge core_clk);
                retention_req <= 1'b0;
                t_rel = $time;
            end
            do_req(1'b0, 13'h1fff, 8'h5a);
        join
        chk(t_take > t_rel, "taken during retention");
        $display("Retention test done");
        @(posedge core_clk);
        req_valid <= 1'b1;
        req_write <= 1'b1;
        req_addr  <= 13'h0123;
        req_wdata <= 8'h99;
        repeat (2) @(posedge core_clk);
        rstn      <= 1'b0;
        req_valid <= 1'b0;
        @(posedge core_clk);
        #1;
        chk_idle("pins not idle in reset");
        @(posedge core_clk);
        rstn <= 1'b1;
        do_req(1'b1, 13'h0123, 8'h66);
        do_req(1'b0, 13'h0123, 8'h66);
        chk(clash === 1'b0, "data pin contention");
        $display("Reset test done");
        stop_test;
    end
endmodule
